// file: shared/lsfb_params.svh
// bridge constants: offsets, config indices, formats, bit phases
`ifndef LSFB_PARAMS_SVH
`define LSFB_PARAMS_SVH

// window offsets
`define LSFB_OFF_OPCODE   3'h0
`define LSFB_OFF_FMT      3'h1
`define LSFB_OFF_ADDR_MID 3'h2
`define LSFB_OFF_ADDR_LOW 3'h3
`define LSFB_OFF_DATA_BYTE_ZERO    3'h4
`define LSFB_WIN_SPAN     13'h0000
// configuration indices
`define LSFB_CFG_STRAP    8'h24
`define LSFB_CFG_BASE_HI  8'h62
`define LSFB_CFG_BASE_LO  8'h63
`define LSFB_CFG_LDN      8'h06
`define LSFB_STRAP_BIT    1
`define LSFB_STRAP_WAIT   2'h3
// instruction formats
`define LSFB_FMT_OP       4'h1
`define LSFB_FMT_OP_D1    4'h2
`define LSFB_FMT_OP_R2    4'h3
`define LSFB_FMT_OP_A3    4'h4
`define LSFB_FMT_A3_W1    4'h5
`define LSFB_FMT_A3_W4    4'h6
`define LSFB_FMT_FAST     4'h7
`define LSFB_FMT_A3_R1    4'h8
`define LSFB_FMT_A3_R2    4'h9
`define LSFB_FMT_A3_R3    4'hA
`define LSFB_FMT_A3_R4    4'hB
// read opcode for host memory reads, dummy byte, no-flash answer
`define LSFB_READ_OP      8'h03
`define LSFB_DUMMY        8'h00
`define LSFB_NO_FLASH     8'hFF
// serial bit phases (link cycles)
`define LSFB_PH_DRIVE     2'h0
`define LSFB_PH_RISE      2'h1
`define LSFB_PH_HOLD      2'h2
`define LSFB_PH_FALL      2'h3
`define LSFB_LAST_BIT     3'h7

`endif

// file: shared/lsfb_pkg.sv
// types shared by the bridge modules
// numbers live in lsfb_params.svh
package lsfb_pkg;

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_UNLOAD} lsfb_host_st_type;
  typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_DONE} lsfb_link_st_type;

  // one planned serial transaction
  typedef struct packed {
    logic        ok;
    logic [63:0] tx;
    logic [3:0]  txn;
    logic [2:0]  rxn;
  } lsfb_job_type;

  typedef struct packed {
    logic s2;
    logic s1;
  } lsfb_sync_type;

endpackage

// file: rtl/lsfb_sync.sv
// two-flop level synchroniser
// assumes d is a slow level from another domain or a pin
`timescale 1ns/100ps
module lsfb_sync (
  input  wire logic clk,   // destination clock
  input  wire logic rst_n, // async reset, active low
  input  wire logic d,     // asynchronous level
  output logic      q      // synchronised level
);
  lsfb_pkg::lsfb_sync_type r;
  lsfb_pkg::lsfb_sync_type nxt;

  // first stage feeds only the second
  always_comb
  begin
    nxt.s1 = d;
    nxt.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= nxt;
  end

  assign q = r.s2;
endmodule

// file: rtl/lsfb_fifo.sv
// synchronous FIFO with valid/ready on both sides
// assumes one clock; depth a power of two
`timescale 1ns/100ps
module lsfb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,       // clock
  input  wire logic         rst_n,     // async reset, active low
  input  wire logic         in_valid,  // write request
  output logic              in_ready,  // not full
  input  wire logic [W-1:0] in_data,   // write data
  output logic              out_valid, // not empty
  input  wire logic         out_ready, // read accept
  output logic [W-1:0]      out_data   // head word
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } lsfb_fifo_type;

  lsfb_fifo_type r;
  lsfb_fifo_type nxt;
  logic          push;
  logic          pop;

  // honest flags straight from the count
  assign in_ready  = (r.cnt != D[AW:0]);
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    nxt = r;
    if (push)
    begin
      nxt.mem[r.wp] = in_data;
      nxt.wp        = r.wp + 1'b1;
    end
    if (pop)
      nxt.rp = r.rp + 1'b1;
    nxt.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= nxt;
  end
endmodule

// file: rtl/lsfb_bridge.sv
// bridge: host I/O window and memory reads onto a serial flash link
// assumes decoded one-cycle host strobes answered by lpc_ready
//
// Summary of operation
// R1: flash pins on only if strap high at reset; status 24h bit 1.
// R2: host memory read becomes a flash read; byte returned to host.
// R3: eight-byte window; base from config 62 and 63, device 6.
// R4: offset 0 holds the opcode, sent first.
// R5: offset 1: format code 7:4, address 19:16 in 3:0.
// R6: offsets 2,3 address 15:0; offsets 4-7 data bytes 0-3.
// R7: writing the format code starts the transaction.
// R8: format 1 sends opcode only.
// R9: format 2 sends opcode and data byte zero.
// R10: format 3 sends opcode, reads two bytes.
// R11: format 4 sends opcode and three address bytes.
// R12: formats 5,6 add one or four written data bytes.
// R13: format 7 adds a dummy byte, reads four bytes.
// R14: format 8 sends opcode, address, reads one byte.
// R15: formats 9,a,b read two, three, four bytes.
// R16: software makes flash ready and write-enabled first.
// R17: received bytes fill data bytes in arrival order.
// R18: select low throughout, msb first, mode 0; no overlapping starts.
`timescale 1ns/100ps
`include "lsfb_params.svh"
module lsfb_bridge (
  input  wire logic        clk,            // core clock
  input  wire logic        rst_n,          // async reset, active low
  input  wire logic        spi_clk,        // serial link clock
  input  wire logic        lpc_io_wr,      // io write strobe
  input  wire logic        lpc_io_rd,      // io read strobe
  input  wire logic [15:0] lpc_addr,       // io address
  input  wire logic [7:0]  lpc_wdata,      // io write data
  input  wire logic        lpc_mem_rd,     // memory read strobe
  input  wire logic [23:0] lpc_maddr,      // memory read address
  output logic      [7:0]  lpc_rdata,      // read data
  output logic             lpc_ready,      // answer pulse
  input  wire logic        cfg_wr,         // config write strobe
  input  wire logic        cfg_rd,         // config read strobe
  input  wire logic [7:0]  cfg_ldn,        // selected logical device
  input  wire logic [7:0]  cfg_idx,        // config index
  input  wire logic [7:0]  cfg_wdata,      // config write data
  output logic      [7:0]  cfg_rdata,      // config read data
  input  wire logic        spi_strap,      // enable strap pin
  input  wire logic        spi_miso,       // data from flash
  output logic             spi_sck,        // serial clock
  output logic             spi_mosi,       // data to flash
  output logic             flash_select_n, // chip select
  output logic             spi_pin_oe      // shared pins driven
);

  typedef struct packed {
    logic [7:0][7:0]           win;
    logic [7:0]                base_hi;
    logic [7:0]                base_lo;
    logic [1:0]                strap_cnt;
    logic                      spi_en;
    lsfb_pkg::lsfb_host_st_type st;
    logic                      req_t;
    logic                      ack_last;
    lsfb_pkg::lsfb_job_type     job;
    logic                      job_mem;
    logic [2:0]                rx_cnt;
    logic [1:0]                wr_idx;
    logic                      mem_pend;
    logic [23:0]               mem_addr;
    logic [7:0]                rdata;
    logic                      ready;
    logic [7:0]                cfg_rdata;
    logic                      pin_oe;
  } lsfb_host_type;

  typedef struct packed {
    lsfb_pkg::lsfb_link_st_type st;
    logic                      req_last;
    logic                      ack_t;
    logic                      sck;
    logic                      mosi;
    logic                      cs_n;
    logic [1:0]                ph;
    logic [2:0]                bitc;
    logic [3:0]                bytec;
    logic [63:0]               sh;
    logic [7:0]                rxb;
    logic [31:0]               rxw;
  } lsfb_link_type;

  lsfb_host_type h_r;
  lsfb_host_type h_nxt;
  lsfb_link_type l_r;
  lsfb_link_type l_nxt;

  logic        strap_s;
  logic        ack_s;
  logic        req_s;
  logic        miso_s;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [7:0]  f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [7:0]  f_out_data;
  logic [15:0] io_off;
  logic        io_hit;

  // byte plan of one format code; unknown codes refused
  function automatic lsfb_pkg::lsfb_job_type plan_job(
    input logic [3:0]  fmt,
    input logic [7:0]  op,
    input logic [23:0] a,
    input logic [31:0] d
  );
    lsfb_pkg::lsfb_job_type j;
    j     = '0;
    j.ok  = 1'b1;
    j.tx  = {op, a, d};                                     // see R4
    j.txn = 4'h4;
    unique case (fmt)
      `LSFB_FMT_OP:    j.txn = 4'h1;                        // see R8
      `LSFB_FMT_OP_D1:
      begin
        j.tx  = {op, d[31:24], 48'h0};                      // see R9
        j.txn = 4'h2;
      end
      `LSFB_FMT_OP_R2:
      begin
        j.txn = 4'h1;                                       // see R10
        j.rxn = 3'h2;
      end
      `LSFB_FMT_OP_A3: j.txn = 4'h4;                        // see R11
      `LSFB_FMT_A3_W1: j.txn = 4'h5;                        // see R12
      `LSFB_FMT_A3_W4: j.txn = 4'h8;                        // see R12
      `LSFB_FMT_FAST:
      begin
        j.tx  = {op, a, `LSFB_DUMMY, 24'h0};                // see R13
        j.txn = 4'h5;
        j.rxn = 3'h4;
      end
      `LSFB_FMT_A3_R1: j.rxn = 3'h1;                        // see R14
      `LSFB_FMT_A3_R2: j.rxn = 3'h2;                        // see R15
      `LSFB_FMT_A3_R3: j.rxn = 3'h3;                        // see R15
      `LSFB_FMT_A3_R4: j.rxn = 3'h4;                        // see R15
      default:         j.ok  = 1'b0;
    endcase
    return j;
  endfunction

  // pins and cross-domain levels, two flops each
  lsfb_sync u_strap (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (spi_strap),
    .q     (strap_s)
  );
  lsfb_sync u_ack (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (l_r.ack_t),
    .q     (ack_s)
  );
  lsfb_sync u_req (
    .clk   (spi_clk),
    .rst_n (rst_n),
    .d     (h_r.req_t),
    .q     (req_s)
  );
  lsfb_sync u_miso (
    .clk   (spi_clk),
    .rst_n (rst_n),
    .d     (spi_miso),
    .q     (miso_s)
  );

  // received bytes queue here
  lsfb_fifo #(
    .W (8),
    .D (8)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // window decode: any base works, not only aligned ones
  assign io_off = lpc_addr - {h_r.base_hi, h_r.base_lo};      // see R3
  assign io_hit = (io_off[15:3] == `LSFB_WIN_SPAN);           // see R3

  // link word is steady once the ack toggle is seen
  assign f_in_valid  = (h_r.st == lsfb_pkg::H_UNLOAD);
  assign f_in_data   = l_r.rxw[{h_r.rx_cnt[1:0], 3'h0} +: 8];
  // drain waits out host window writes
  assign f_out_ready = !(lpc_io_wr && io_hit);

  // host-domain control
  always_comb
  begin
    lsfb_pkg::lsfb_job_type j;
    logic                   idle_ok;
    h_nxt   = h_r;
    h_nxt.ready = 1'b0;
    j       = '0;
    // a new job needs an idle engine and an empty queue
    idle_ok = (h_r.st == lsfb_pkg::H_IDLE) && !f_out_valid;

    // synchroniser resets to 0, so follow the strap until it has settled
    if (h_r.strap_cnt != `LSFB_STRAP_WAIT)
    begin
      h_nxt.strap_cnt = h_r.strap_cnt + 2'h1;
      h_nxt.spi_en     = strap_s;                             // see R1
    end
    h_nxt.pin_oe = h_r.spi_en;                                // see R1

    // configuration space
    if (cfg_wr && cfg_ldn == `LSFB_CFG_LDN)
    begin
      if (cfg_idx == `LSFB_CFG_BASE_HI)
        h_nxt.base_hi = cfg_wdata;                            // see R3
      if (cfg_idx == `LSFB_CFG_BASE_LO)
        h_nxt.base_lo = cfg_wdata;                            // see R3
    end
    if (cfg_rd)
    begin
      h_nxt.cfg_rdata = '0;
      if (cfg_idx == `LSFB_CFG_STRAP)
        h_nxt.cfg_rdata[`LSFB_STRAP_BIT] = h_r.spi_en;        // see R1
      else if (cfg_ldn == `LSFB_CFG_LDN && cfg_idx == `LSFB_CFG_BASE_HI)
        h_nxt.cfg_rdata = h_r.base_hi;
      else if (cfg_ldn == `LSFB_CFG_LDN && cfg_idx == `LSFB_CFG_BASE_LO)
        h_nxt.cfg_rdata = h_r.base_lo;
    end

    // window reads
    if (lpc_io_rd && io_hit)
    begin
      h_nxt.rdata = h_r.win[io_off[2:0]];                     // see R6
      h_nxt.ready = 1'b1;
    end

    // window writes; writing offset 1 also launches
    if (lpc_io_wr && io_hit)
    begin
      h_nxt.win[io_off[2:0]] = lpc_wdata;                     // see R5
      h_nxt.ready = 1'b1;
      if (io_off[2:0] == `LSFB_OFF_FMT)
      begin
        j = plan_job(lpc_wdata[7:4], h_r.win[`LSFB_OFF_OPCODE],
                     {4'h0, lpc_wdata[3:0], h_r.win[`LSFB_OFF_ADDR_MID],
                      h_r.win[`LSFB_OFF_ADDR_LOW]},
                     {h_r.win[4], h_r.win[5], h_r.win[6], h_r.win[7]});
        // a start while busy is dropped; the value is still stored
        if (j.ok && idle_ok && h_r.spi_en)                   // see R18
        begin
          h_nxt.job     = j;                                  // see R7
          h_nxt.job_mem = 1'b0;
          h_nxt.wr_idx  = '0;
          h_nxt.req_t   = !h_r.req_t;
          h_nxt.st      = lsfb_pkg::H_WAIT;
          idle_ok       = 1'b0;
        end
      end
    end

    // memory reads wait for a free engine
    if (lpc_mem_rd)
    begin
      h_nxt.mem_pend = 1'b1;
      h_nxt.mem_addr = lpc_maddr;
    end
    if (h_r.mem_pend && idle_ok)
    begin
      h_nxt.mem_pend = 1'b0;
      if (h_r.spi_en)
      begin
        h_nxt.job = plan_job(`LSFB_FMT_A3_R1, `LSFB_READ_OP,  // see R2
                             h_r.mem_addr, 32'h0);
        h_nxt.job_mem = 1'b1;
        h_nxt.req_t   = !h_r.req_t;
        h_nxt.st      = lsfb_pkg::H_WAIT;
      end
      else
      begin
        h_nxt.rdata = `LSFB_NO_FLASH;
        h_nxt.ready = 1'b1;
      end
    end

    // engine progress
    unique case (h_r.st)
      lsfb_pkg::H_IDLE:
      begin
      end
      lsfb_pkg::H_WAIT:
      begin
        if (ack_s != h_r.ack_last)
        begin
          h_nxt.ack_last = ack_s;
          h_nxt.rx_cnt   = '0;
          h_nxt.st       = (h_r.job.rxn == '0) ? lsfb_pkg::H_IDLE
                                               : lsfb_pkg::H_UNLOAD;
        end
      end
      lsfb_pkg::H_UNLOAD:
      begin
        // queue full stalls the unload
        if (f_in_ready)
        begin
          h_nxt.rx_cnt = h_r.rx_cnt + 3'h1;
          if (h_r.rx_cnt + 3'h1 == h_r.job.rxn)
            h_nxt.st = lsfb_pkg::H_IDLE;
        end
      end
    endcase

    // drain: bytes land in arrival order
    if (f_out_valid && f_out_ready)
    begin
      if (h_r.job_mem)
      begin
        h_nxt.rdata = f_out_data;                             // see R2
        h_nxt.ready = 1'b1;
      end
      else
      begin
        h_nxt.win[{1'b1, h_r.wr_idx}] = f_out_data;           // see R17
        h_nxt.wr_idx = h_r.wr_idx + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      h_r <= '0;
    else
      h_r <= h_nxt;
  end

  // link-domain serial engine; job fields are held stable while it runs
  always_comb
  begin
    logic [7:0] b;
    logic [3:0] ri;
    l_nxt = l_r;
    b     = {l_r.rxb[6:0], miso_s};
    ri    = l_r.bytec - h_r.job.txn;
    unique case (l_r.st)
      lsfb_pkg::L_IDLE:
      begin
        if (req_s != l_r.req_last)
        begin
          l_nxt.req_last = req_s;
          l_nxt.sh       = h_r.job.tx;
          l_nxt.cs_n     = 1'b0;                              // see R18
          l_nxt.ph       = `LSFB_PH_DRIVE;
          l_nxt.bitc     = '0;
          l_nxt.bytec    = '0;
          l_nxt.rxw      = '0;
          l_nxt.st       = lsfb_pkg::L_SHIFT;
        end
      end
      lsfb_pkg::L_SHIFT:
      begin
        unique case (l_r.ph)
          `LSFB_PH_DRIVE:
          begin
            // mode 0: data settles while the clock is low
            l_nxt.mosi = (l_r.bytec < h_r.job.txn) && l_r.sh[63]; // see R18
            l_nxt.ph   = `LSFB_PH_RISE;
          end
          `LSFB_PH_RISE:
          begin
            l_nxt.sck = 1'b1;
            l_nxt.ph  = `LSFB_PH_HOLD;
          end
          `LSFB_PH_HOLD:
            l_nxt.ph = `LSFB_PH_FALL;
          `LSFB_PH_FALL:
          begin
            // input sampled at the rise arrives here through two flops
            l_nxt.sck  = 1'b0;
            l_nxt.rxb  = b;
            l_nxt.sh   = {l_r.sh[62:0], 1'b0};                // see R18
            l_nxt.bitc = l_r.bitc + 3'h1;
            l_nxt.ph   = `LSFB_PH_DRIVE;
            if (l_r.bitc == `LSFB_LAST_BIT)
            begin
              if (l_r.bytec >= h_r.job.txn)
                l_nxt.rxw[{ri[1:0], 3'h0} +: 8] = b;          // see R17
              l_nxt.bytec = l_r.bytec + 4'h1;
              if (l_r.bytec + 4'h1 == h_r.job.txn + {1'b0, h_r.job.rxn})
                l_nxt.st = lsfb_pkg::L_DONE;
            end
          end
        endcase
      end
      lsfb_pkg::L_DONE:
      begin
        l_nxt.cs_n  = 1'b1;                                   // see R18
        l_nxt.mosi  = 1'b0;
        l_nxt.ack_t = !l_r.ack_t;
        l_nxt.st    = lsfb_pkg::L_IDLE;
      end
      default:
        l_nxt.st = lsfb_pkg::L_IDLE;
    endcase
  end

  // chip select idles high out of reset
  always_ff @(posedge spi_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      l_r      <= '0;
      l_r.cs_n <= 1'b1;
    end
    else
      l_r <= l_nxt;
  end

  // outputs straight from flops
  assign lpc_rdata      = h_r.rdata;
  assign lpc_ready      = h_r.ready;
  assign cfg_rdata      = h_r.cfg_rdata;
  assign spi_pin_oe     = h_r.pin_oe;
  assign spi_sck        = l_r.sck;
  assign spi_mosi       = l_r.mosi;
  assign flash_select_n = l_r.cs_n;
endmodule

// file: verif/lsfb_flash_model.sv
// flash stand-in: logs frame bytes, answers 3Ch plus byte position
// assumes mode 0 from the bridge
`timescale 1ns/100ps
module lsfb_flash_model (
  input  logic spi_sck,        // serial clock
  input  logic spi_mosi,       // data in
  input  logic flash_select_n, // select
  output logic spi_miso        // data out
);
  logic [7:0] cap [0:15];
  logic [7:0] sh;
  int         bc = 0;
  int         pos = 0;
  int         nfr = 0;
  function automatic logic pat(input int p, input int b);
    logic [7:0] v;
    v = 8'h3C + 8'(p);
    return v[7 - b];
  endfunction
  initial spi_miso = 1'b0;
  // first bit out before the first rise
  always @(negedge flash_select_n)
  begin
    bc = 0;
    pos = 0;
    nfr++;
    spi_miso = pat(0, 0);
  end
  // msb first, taken on the rise
  always @(posedge spi_sck)
    if (!flash_select_n)
    begin
      sh = {sh[6:0], spi_mosi};
      bc++;
      if (bc == 8)
      begin
        cap[pos[3:0]] = sh;
        pos++;
        bc = 0;
      end
    end
  // next bit after each fall; a released line shows the inverse
  always @(negedge spi_sck)
    if (!flash_select_n)
      spi_miso = pat(pos, bc);
  always @(posedge flash_select_n)
    spi_miso = ~spi_miso;
endmodule

// file: verif/lsfb_bridge_properties.sv
// pin-level checks of the bridge, bound into each instance
// assumes the base is set before window accesses
`timescale 1ns/100ps
module lsfb_bridge_properties (
  input logic        clk,            // core clock
  input logic        rst_n,          // reset
  input logic        spi_clk,        // link clock
  input logic        lpc_io_wr,      // io write
  input logic        lpc_io_rd,      // io read
  input logic [15:0] lpc_addr,       // io address
  input logic        lpc_mem_rd,     // memory read
  input logic [7:0]  lpc_rdata,      // read data
  input logic        lpc_ready,      // answer
  input logic        cfg_wr,         // config write
  input logic        cfg_rd,         // config read
  input logic [7:0]  cfg_ldn,        // device
  input logic [7:0]  cfg_idx,        // index
  input logic [7:0]  cfg_wdata,      // config in
  input logic [7:0]  cfg_rdata,      // config out
  input logic        spi_sck,        // serial clock
  input logic        spi_mosi,       // to flash
  input logic        flash_select_n, // select
  input logic        spi_pin_oe      // pins on
);
  logic [15:0] base_r;
  logic        mem_r;
  logic [15:0] off;
  logic        io;
  // shadow of the window base and of a memory read still open
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {base_r, mem_r} <= 17'h00000;
    else
    begin
      if (cfg_wr && cfg_ldn == 8'h06 && cfg_idx == 8'h62)
        base_r[15:8] <= cfg_wdata;
      if (cfg_wr && cfg_ldn == 8'h06 && cfg_idx == 8'h63)
        base_r[7:0] <= cfg_wdata;
      mem_r <= lpc_mem_rd | (mem_r & ~lpc_ready);
    end
  // subtraction, so any base works without alignment
  assign off = lpc_addr - base_r;
  assign io = lpc_io_wr | lpc_io_rd;

  chk_sck_idle_low: assert property (@(posedge spi_clk) disable iff (!rst_n)
    flash_select_n |-> !spi_sck) else $error("clock high while deselected");
  chk_mosi_held_high: assert property (@(posedge spi_clk) disable iff (!rst_n)
    spi_sck |-> $stable(spi_mosi)) else $error("data moved while clock high");
  chk_pins_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !spi_pin_oe |-> flash_select_n) else $error("select low with pins off");
  chk_window_answer: assert property (@(posedge clk) disable iff (!rst_n)
    io && off < 16'h0008 |=> lpc_ready ##1 !lpc_ready) else $error("window access unanswered");
  chk_outside_silent: assert property (@(posedge clk) disable iff (!rst_n)
    io && off > 16'h0007 && !mem_r |=> !lpc_ready) else $error("outside access answered");
  chk_strap_status: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rd && cfg_idx == 8'h24 |-> ##2 cfg_rdata[1] == spi_pin_oe) else $error("strap bit wrong");
  chk_cfg_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rd && !(cfg_idx inside {8'h24, 8'h62, 8'h63}) |-> ##2 cfg_rdata == 8'h00)
    else $error("unmapped index not zero");
  chk_base_readback: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rd && cfg_ldn == 8'h06 && cfg_idx == 8'h62 |-> ##2 cfg_rdata == base_r[15:8])
    else $error("base high byte wrong");
  chk_no_flash_ff: assert property (@(posedge clk) disable iff (!rst_n)
    lpc_mem_rd && !spi_pin_oe |-> ##2 (lpc_ready && lpc_rdata == 8'hFF))
    else $error("no-flash answer wrong");

  cov_frame: cover property (@(posedge spi_clk) disable iff (!rst_n) $fell(flash_select_n));
  cov_mem_answer: cover property (@(posedge clk) disable iff (!rst_n) mem_r && lpc_ready);
  cov_refused: cover property (@(posedge clk) disable iff (!rst_n) io && off > 16'h0007);
endmodule

bind lsfb_bridge lsfb_bridge_properties chk_u (.*);

// file: verif/lsfb_bridge_test.sv
// bridge bench: config, formats, memory read, refusals, strap off
// assumes the flash model's answer pattern
`timescale 1ns/100ps
module lsfb_bridge_test;
  logic        clk, rst_n, spi_clk, spi_strap, spi_miso, lpc_io_wr, lpc_io_rd;
  logic        lpc_mem_rd, cfg_wr, cfg_rd, lpc_ready, spi_sck, spi_mosi;
  logic        flash_select_n, spi_pin_oe;
  logic [15:0] lpc_addr, base;
  logic [23:0] lpc_maddr, ma;
  logic [7:0]  lpc_wdata, lpc_rdata, cfg_ldn, cfg_idx, cfg_wdata, cfg_rdata, op, d8;
  logic [7:0]  v [0:7];
  logic [7:0]  ex [0:7];
  logic [19:0] ad;
  logic [8:0]  e;
  logic [8:0]  exp_q [$];
  int          fails = 0, cmp_count = 0, cyc = 0, nt, n0;
  int          rxn [1:11] = '{0, 0, 2, 0, 0, 0, 4, 1, 2, 3, 4};

  lsfb_bridge dut_u (.clk, .rst_n, .spi_clk, .lpc_io_wr, .lpc_io_rd, .lpc_addr,
    .lpc_wdata, .lpc_mem_rd, .lpc_maddr, .lpc_rdata, .lpc_ready, .cfg_wr, .cfg_rd,
    .cfg_ldn, .cfg_idx, .cfg_wdata, .cfg_rdata, .spi_strap, .spi_miso, .spi_sck,
    .spi_mosi, .flash_select_n, .spi_pin_oe);
  lsfb_flash_model fm (.spi_sck, .spi_mosi, .flash_select_n, .spi_miso);

  // two unrelated clocks
  always #2 clk = ~clk;
  always #7.5 spi_clk = ~spi_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // oldest note per answer, read where settled; unnoted answers fail
  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      final_report();
    end
    if (lpc_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk({7'h00, lpc_ready}, 8'h00);
      else
      begin
        e = exp_q.pop_front();
        if (e[8])
          chk(lpc_rdata, e[7:0]);
      end
    end
  end

  task automatic cfg(input logic w, input logic [7:0] l, i, d);
    @(negedge clk);
    {cfg_wr, cfg_rd, cfg_ldn, cfg_idx, cfg_wdata} = {w, !w, l, i, d};
    @(negedge clk);
    {cfg_wr, cfg_rd} = 2'b00;
    @(negedge clk);
    if (!w)
      chk(cfg_rdata, d);
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input logic ans);
    if (ans)
      exp_q.push_back({!w, d});
    @(negedge clk);
    {lpc_io_wr, lpc_io_rd, lpc_addr, lpc_wdata} = {w, !w, a, d};
    @(negedge clk);
    {lpc_io_wr, lpc_io_rd} = 2'b00;
    repeat (2) @(negedge clk);
  endtask
  // k 0 or 1: select reaches that level; k 2: every answer seen
  task automatic hold_until(input int k);
    int n;
    n = 0;
    while (n < 3000 && (k == 2 ? exp_q.size() != 0 : flash_select_n !== k[0]))
    begin
      @(negedge clk);
      n++;
    end
    chk(8'(n / 3000), 8'h00);
  endtask
  task automatic mem(input logic [23:0] a, input logic [7:0] d);
    exp_q.push_back({1'b1, d});
    @(negedge clk);
    {lpc_mem_rd, lpc_maddr} = {1'b1, a};
    @(negedge clk);
    lpc_mem_rd = 1'b0;
    hold_until(2);
  endtask
  // strap is set before reset so it is steady when captured
  task automatic restart(input logic s);
    spi_strap = s;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  initial
  begin
    {clk, spi_clk, lpc_io_wr, lpc_io_rd, lpc_mem_rd, cfg_wr, cfg_rd} = 7'h00;
    {lpc_addr, lpc_maddr, lpc_wdata, cfg_ldn, cfg_idx, cfg_wdata} = 72'h0;
    void'($urandom(34));
    base = 16'($urandom);
    restart(1'b1);
    cfg(1'b1, 8'h06, 8'h62, base[15:8]);
    cfg(1'b1, 8'h06, 8'h63, base[7:0]);
    cfg(1'b1, 8'h05, 8'h62, ~base[15:8]);
    cfg(1'b0, 8'h06, 8'h62, base[15:8]);
    cfg(1'b0, 8'h06, 8'h63, base[7:0]);
    cfg(1'b0, 8'h00, 8'h24, 8'h02);
    cfg(1'b0, 8'h06, 8'h25, 8'h00);
    $display("config test done");
    // code 1 sends write enable first
    for (int f = 1; f < 12; f++)
    begin
      op = (f == 1) ? 8'h06 : 8'($urandom);
      ad = 20'($urandom);
      for (int k = 0; k < 8; k++)
        v[k] = 8'($urandom);
      {v[0], v[2], v[3]} = {op, ad[15:0]};
      for (int k = 0; k < 8; k++)
        if (k != 1)
          io(1'b1, base + 16'(k), v[k], 1'b1);
      n0 = fm.nfr;
      io(1'b1, base + 16'd1, {4'(f), ad[19:16]}, 1'b1);
      hold_until(0);
      io(1'b1, base + 16'd1, {4'(f), ad[19:16]}, 1'b1);
      hold_until(1);
      repeat (20) @(negedge clk);
      nt = (f < 4) ? 1 : 4;
      {ex[0], ex[1], ex[2], ex[3]} = {op, 4'h0, ad};
      ex[1] = (f == 2) ? v[4] : ex[1];
      {ex[4], ex[5], ex[6], ex[7]} = (f == 7) ? 32'h0 : {v[4], v[5], v[6], v[7]};
      nt += (f == 2 || f == 5 || f == 7) ? 1 : (f == 6) ? 4 : 0;
      chk(8'(fm.nfr - n0), 8'h01);
      chk(8'(fm.pos), 8'(nt + rxn[f]));
      for (int k = 0; k < nt; k++)
        chk(fm.cap[k], ex[k]);
      io(1'b0, base, op, 1'b1);
      io(1'b0, base + 16'd1, {4'(f), ad[19:16]}, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
        d8 = (k < rxn[f]) ? 8'h3C + 8'(nt + k) : v[4 + k];
        io(1'b0, base + 16'(4 + k), d8, 1'b1);
      end
    end
    $display("format test done");
    io(1'b1, base + 16'd8, 8'h5A, 1'b0);
    io(1'b0, base - 16'd1, 8'h00, 1'b0);
    $display("window edge test done");
    // the fifth byte of a read frame carries 3Ch plus 4
    ma = 24'($urandom);
    mem(ma, 8'h40);
    chk(fm.cap[0], 8'h03);
    for (int k = 1; k < 4; k++)
      chk(fm.cap[k], 8'(ma >> (24 - 8 * k)));
    $display("memory read test done");
    n0 = fm.nfr;
    restart(1'b0);
    cfg(1'b0, 8'h00, 8'h24, 8'h00);
    mem(ma, 8'hFF);
    chk(8'(fm.nfr - n0), 8'h00);
    $display("strap test done");
    final_report();
  end
endmodule
